// *** nand_card_pkg.sv ***
// Purpose: shared types and constants of the NAND / card access engine
// Assumes: one clock, all phase counts in clock cycles
// Notes: bank codes follow the external bank numbering
package nand_card_pkg;
    // Bank codes
    localparam logic [1:0] BANK_N2 = 2'h0;
    localparam logic [1:0] BANK_N3 = 2'h1;
    localparam logic [1:0] BANK_CARD = 2'h2;
    // Card spaces
    localparam logic [1:0] SPC_COMMON = 2'h0;
    localparam logic [1:0] SPC_ATTR = 2'h1;
    localparam logic [1:0] SPC_IO = 2'h2;
    // Access sizes
    localparam logic [1:0] SZ_8 = 2'h0;
    localparam logic [1:0] SZ_16 = 2'h1;
    localparam logic [1:0] SZ_32 = 2'h2;
    // Latch enable address bits
    localparam int ALE_BIT = 17;
    localparam int CLE_BIT = 16;
    // Reset values
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    // Engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RDY = 3'b001,
        ST_SETUP = 3'b010,
        ST_CMD = 3'b011,
        ST_HOLD = 3'b100,
        ST_DONE = 3'b101
    } state_t;
    // One system-side request
    typedef struct packed {
        logic write;
        logic [1:0] bank;
        logic [1:0] space;
        logic [1:0] size;
        logic [25:0] addr;
        logic [31:0] wdata;
    } req_t;
    // Phase timing set
    typedef struct packed {
        logic [7:0] setup;
        logic [7:0] wait_c;
        logic [7:0] hold;
        logic [7:0] hiz;
    } tim_t;
endpackage

// *** nand_card_ctrl.sv ***
// Purpose: strobed asynchronous access engine for two NAND banks and one card bank
// Assumes: requests and pins synchronous to mclk_i
// Notes: one request at a time, answered by a one-cycle rsp_valid_o
module nand_card_ctrl import nand_card_pkg::*; (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire req_t req_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire tim_t tim_i,
    input wire logic [1:0] nand_wide_i,
    output logic rsp_valid_o,
    output logic rsp_error_o,
    output logic [31:0] rsp_rdata_o,
    output logic [25:0] mem_addr_o,
    input wire logic [15:0] data_i,
    output logic [15:0] data_o,
    output logic data_oe_o,
    output logic [1:0] bank_select_n_o,
    output logic out_strobe_n_o,
    output logic write_strobe_n_o,
    output logic io_read_strobe_n_o,
    output logic io_write_strobe_n_o,
    output logic space_select_n_o,
    output logic card_select_lo_n_o,
    output logic card_select_hi_n_o,
    input wire logic [1:0] ready_busy_i,
    input wire logic wait_in_n_i,
    input wire logic card_irq_in_i,
    input wire logic card_present_i,
    input wire logic io_wide_indicate_n_i,
    output logic card_irq_o,
    output logic io_wide_fault_o
);
    // Number of memory accesses for one request
    function automatic logic [2:0] beats(input logic [1:0] sz, input logic narrow);
        logic [2:0] n;
        n = 3'h1;
        if (narrow)
            n = (sz == SZ_32) ? 3'h4 : (sz == SZ_16) ? 3'h2 : 3'h1;
        else if (sz == SZ_32)
            n = 3'h2;
        return n;
    endfunction

    state_t st_r, st_nxt; // Engine state
    req_t rq_r, rq_nxt; // Latched request
    logic [7:0] cnt_r, cnt_nxt; // Phase counter
    logic [7:0] hz_r, hz_nxt; // Bus high-Z counter
    logic [2:0] beat_r, beat_nxt; // Current beat index
    logic [2:0] last_r, last_nxt; // Last beat index
    logic narrow_r, narrow_nxt; // Byte-wide target
    logic err_r, err_nxt; // Error answer
    logic [31:0] rd_r, rd_nxt; // Read assembly
    logic [25:0] ad_r, ad_nxt; // Address pins
    logic [15:0] wd_r, wd_nxt; // Write data pins
    logic irq_r, irq_nxt; // Card interrupt copy
    logic iof_r, iof_nxt; // Wide indicator fault
    logic act; // Access in progress
    logic nand_t; // Target is a NAND bank
    logic strb; // Command strobe phase
    logic [7:0] wmin; // Wait count, floor one
    logic [7:0] hld; // Hold count minus one
    logic bad_w, bad_c; // Refusal causes

    assign act = (st_r == ST_RDY) || (st_r == ST_SETUP)
                 || (st_r == ST_CMD) || (st_r == ST_HOLD);
    assign nand_t = (rq_r.bank != BANK_CARD);
    assign strb = (st_r == ST_CMD) && (st_r != ST_RDY);
    assign wmin = (tim_i.wait_c == CNT_RST) ? 8'h01 : tim_i.wait_c;
    assign hld = (tim_i.hold == CNT_RST) ? CNT_RST : tim_i.hold - 8'h01;
    assign bad_w = (req_i.bank != BANK_CARD) && !nand_wide_i[req_i.bank[0]]
                   ? 1'b0 : (req_i.bank != BANK_CARD) && req_i.write
                   && (req_i.size == SZ_8);
    assign bad_c = (req_i.bank == BANK_CARD) && !card_present_i;

    // Next state and datapath of the access engine
    always_comb
    begin
        st_nxt = st_r;
        rq_nxt = rq_r;
        cnt_nxt = cnt_r;
        hz_nxt = (hz_r != CNT_RST) ? hz_r - 8'h01 : hz_r;
        beat_nxt = beat_r;
        last_nxt = last_r;
        narrow_nxt = narrow_r;
        err_nxt = err_r;
        rd_nxt = rd_r;
        ad_nxt = ad_r;
        wd_nxt = wd_r;
        irq_nxt = card_irq_in_i;
        iof_nxt = act && !nand_t && (rq_r.space == SPC_IO)
                  && io_wide_indicate_n_i;
        case (st_r)
            ST_IDLE:
            begin
                if (req_valid_i)
                begin
                    rq_nxt = req_i;
                    narrow_nxt = (req_i.bank != BANK_CARD) && !nand_wide_i[req_i.bank[0]];
                    last_nxt = beats(req_i.size, narrow_nxt) - 3'h1;
                    beat_nxt = 3'h0;
                    err_nxt = bad_w || bad_c;
                    rd_nxt = DATA_RST;
                    st_nxt = (bad_w || bad_c) ? ST_DONE : ST_RDY;
                end
            end
            ST_RDY:
            begin
                // Hold until both NAND parts report ready
                if (&ready_busy_i)
                begin
                    st_nxt = ST_SETUP;
                    cnt_nxt = tim_i.setup;
                    hz_nxt = tim_i.hiz;
                    ad_nxt = narrow_r ? rq_r.addr + {23'h0, beat_r}
                             : (rq_r.size == SZ_8) ? rq_r.addr
                             : rq_r.addr + {22'h0, beat_r, 1'b0};
                    if (narrow_r)
                        wd_nxt = {8'h00, rq_r.wdata[{beat_r[1:0], 3'h0} +: 8]};
                    else if (rq_r.size == SZ_8)
                        wd_nxt = {rq_r.wdata[7:0], rq_r.wdata[7:0]};
                    else
                        wd_nxt = rq_r.wdata[{beat_r[0], 4'h0} +: 16];
                end
            end
            ST_SETUP:
            begin
                if (cnt_r == CNT_RST)
                begin
                    st_nxt = ST_CMD;
                    cnt_nxt = wmin;
                end
                else
                    cnt_nxt = cnt_r - 8'h01;
            end
            ST_CMD:
            begin
                // Strobe ends only when count spent and wait released
                if ((cnt_r == CNT_RST) && wait_in_n_i)
                begin
                    st_nxt = ST_HOLD;
                    cnt_nxt = hld;
                    if (narrow_r)
                        rd_nxt[{beat_r[1:0], 3'h0} +: 8] = data_i[7:0];
                    else if (rq_r.size == SZ_8)
                        rd_nxt[7:0] = rq_r.addr[0] ? data_i[15:8] : data_i[7:0];
                    else
                        rd_nxt[{beat_r[0], 4'h0} +: 16] = data_i;
                end
                else if (cnt_r != CNT_RST)
                    cnt_nxt = cnt_r - 8'h01;
            end
            ST_HOLD:
            begin
                if (cnt_r == CNT_RST)
                begin
                    if (beat_r == last_r)
                        st_nxt = ST_DONE;
                    else
                    begin
                        beat_nxt = beat_r + 3'h1;
                        st_nxt = ST_RDY;
                    end
                end
                else
                    cnt_nxt = cnt_r - 8'h01;
            end
            ST_DONE:
                st_nxt = ST_IDLE;
            default:
                st_nxt = ST_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_r <= ST_IDLE;
            rq_r <= '0;
            cnt_r <= CNT_RST;
            hz_r <= CNT_RST;
            beat_r <= 3'h0;
            last_r <= 3'h0;
            narrow_r <= 1'b0;
            err_r <= 1'b0;
            rd_r <= DATA_RST;
            ad_r <= '0;
            wd_r <= 16'h0000;
            irq_r <= 1'b0;
            iof_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            rq_r <= rq_nxt;
            cnt_r <= cnt_nxt;
            hz_r <= hz_nxt;
            beat_r <= beat_nxt;
            last_r <= last_nxt;
            narrow_r <= narrow_nxt;
            err_r <= err_nxt;
            rd_r <= rd_nxt;
            ad_r <= ad_nxt;
            wd_r <= wd_nxt;
            irq_r <= irq_nxt;
            iof_r <= iof_nxt;
        end
    end

    // System side handshake and answer
    assign req_ready_o = (st_r == ST_IDLE);
    assign rsp_valid_o = (st_r == ST_DONE);
    assign rsp_error_o = (st_r == ST_DONE) && err_r;
    assign rsp_rdata_o = rd_r;
    assign card_irq_o = irq_r;
    assign io_wide_fault_o = iof_r;

    // Memory pins decoded from registered state
    assign mem_addr_o = ad_r;
    assign data_o = wd_r;
    assign data_oe_o = rq_r.write && (hz_r == CNT_RST) && act
                       && (st_r != ST_RDY);
    assign bank_select_n_o[0] = !(act && (rq_r.bank == BANK_N2));
    assign bank_select_n_o[1] = !(act && (rq_r.bank == BANK_N3));
    assign out_strobe_n_o = !(strb && !rq_r.write
                              && (nand_t || (rq_r.space != SPC_IO)));
    assign write_strobe_n_o = !(strb && rq_r.write
                                && (nand_t || (rq_r.space != SPC_IO)));
    assign io_read_strobe_n_o = !(strb && !rq_r.write && !nand_t
                                  && (rq_r.space == SPC_IO));
    assign io_write_strobe_n_o = !(strb && rq_r.write && !nand_t
                                   && (rq_r.space == SPC_IO));
    assign space_select_n_o = !act || nand_t || (rq_r.space == SPC_COMMON);
    assign card_select_lo_n_o = !(act && !nand_t
                                  && ((rq_r.size != SZ_8) || !rq_r.addr[0]));
    assign card_select_hi_n_o = !(act && !nand_t
                                  && ((rq_r.size != SZ_8) || rq_r.addr[0]));

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    property p_banks;
        !(&{bank_select_n_o, card_select_lo_n_o, card_select_hi_n_o})
        |-> act;
    endproperty
    a_banks: assert property (p_banks) else $error("select outside access");
    property p_setup;
        (st_r == ST_SETUP) && $past(st_r) == ST_RDY |-> ##1 $stable(mem_addr_o);
    endproperty
    a_setup: assert property (p_setup) else $error("address moved in setup");
    property p_wait;
        $rose(strb) |-> strb[*2];
    endproperty
    a_wait: assert property (p_wait) else $error("strobe too short");
    property p_hold;
        $fell(strb) |-> $stable(mem_addr_o) && $stable(data_o) && (st_r == ST_HOLD);
    endproperty
    a_hold: assert property (p_hold) else $error("hold broken");
    // Bus stays released in the first setup cycle unless no high-Z time is asked
    property p_hiz;
        data_oe_o |-> rq_r.write && ((tim_i.hiz == CNT_RST) || ($past(st_r) != ST_RDY));
    endproperty
    a_hiz: assert property (p_hiz) else $error("bus driven early");
    property p_io;
        !io_read_strobe_n_o || !io_write_strobe_n_o
        |-> out_strobe_n_o && write_strobe_n_o && !space_select_n_o;
    endproperty
    a_io: assert property (p_io) else $error("io strobe mix");
    property p_card;
        (st_r == ST_IDLE) && req_valid_i && bad_c |=> rsp_error_o;
    endproperty
    a_card: assert property (p_card) else $error("absent card not refused");
    property p_rdy;
        (st_r == ST_RDY) && !(&ready_busy_i) |=> (st_r == ST_RDY) && act;
    endproperty
    a_rdy: assert property (p_rdy) else $error("left wait while busy");
    property p_order;
        $rose(st_r == ST_CMD) |-> $past(st_r) == ST_SETUP;
    endproperty
    a_order: assert property (p_order) else $error("phase order broken");
endmodule // nand_card_ctrl

// *** nand_card_mem.sv ***
// Purpose: behavioural flash / card partner for the access engine bench
// Assumes: strobes and selects change just after mclk_i rising edges
// Notes: counts strobes, records write beats, busy after writes, optional wait stretch
module nand_card_mem import nand_card_pkg::*; (
    input wire logic mclk_i,
    input wire logic [25:0] mem_addr_i,
    input wire logic [15:0] data_i,
    input wire logic oe_i,
    input wire logic [1:0] bank_select_n_i,
    input wire logic [3:0] strb_n_i, // {out, write, io read, io write}
    input wire logic [2:0] card_i, // {space, select lo, select hi}
    output logic [15:0] data_o,
    output logic [1:0] ready_busy_o,
    output logic wait_in_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int busy_len = 0, busy_cnt = 0, wait_len = 0, wcnt = 0; // Slow-answer knobs
    int n_rd, n_wr, n_ior, n_iow, lw, su, viol;
    int min_w = 999, min_su = 999;
    int w_last = 0; // Length of the last strobe
    logic [25:0] wa[$]; // Write beat addresses
    logic [15:0] wd[$]; // Write beat data
    logic [2:0] card_seen;
    logic [1:0] bank_seen;
    logic [3:0] prev_n = 4'hf, fall, rise;
    logic [15:0] last = 16'h0000;
    // Read data from address, else a bus that toggles every cycle
    assign data_o = (!strb_n_i[3] || !strb_n_i[1]) ? (mem_addr_i[15:0] ^ 16'ha5c3) : ~last;
    assign ready_busy_o = {2{busy_cnt == 0}};
    assign wait_in_n_o = (wcnt == 0);
    // Watch strobes on every rising edge
    always @(posedge mclk_i)
    begin
        fall = prev_n & ~strb_n_i;
        rise = ~prev_n & strb_n_i;
        last <= data_o;
        if (&strb_n_i && (~&bank_select_n_i || !card_i[1] || !card_i[0]))
            su++;
        else if (&strb_n_i)
            su = 0;
        if (!(&strb_n_i))
            lw++;
        n_rd += fall[3];
        n_wr += fall[2];
        n_ior += fall[1];
        n_iow += fall[0];
        if (|fall)
        begin
            card_seen = card_i;
            bank_seen = ~bank_select_n_i;
            if (su < min_su)
                min_su = su;
            su = 0;
            if (ready_busy_o != 2'b11 || (fall[2] | fall[0]) != oe_i)
                viol++;
            if (fall[2] | fall[0])
            begin
                wa.push_back(mem_addr_i);
                wd.push_back(data_i);
            end
        end
        if (|rise)
        begin
            if (lw < min_w)
                min_w = lw;
            w_last = lw;
            lw = 0;
        end
        // Busy after each write strobe (not I/O write), stretch each strobe
        busy_cnt <= rise[2] ? busy_len : (busy_cnt > 0 ? busy_cnt - 1 : 0);
        wcnt <= (|fall) ? wait_len : (wcnt > 0 ? wcnt - 1 : 0);
        prev_n = strb_n_i;
    end
endmodule // nand_card_mem

// *** nand_pccard_access_controller_test.sv ***
// Purpose: directed bench of the NAND / card access engine
// Assumes: one request at a time, inputs driven 1 ns after rising edges
// Notes: expectations built from timing inputs and address pattern
module nand_pccard_access_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    import nand_card_pkg::*;
    logic mclk_i = 0, nrst_i = 0, req_valid_i = 0, req_ready_o, rsp_valid_o, rsp_error_o;
    logic data_oe_o, card_irq_in_i = 0, card_present_i = 0, card_irq_o, io_wide_fault_o;
    logic out_n, wr_n, ior_n, iow_n, ssel_n, clo_n, chi_n, wait_n;
    logic [1:0] nand_wide_i = 2'b10, bsel_n, rb;
    logic [15:0] din, dout;
    logic [25:0] addr;
    logic [31:0] rsp_rdata_o, rdat;
    logic rerr;
    req_t req_i = '0;
    tim_t tim_i = '{8'h02, 8'h03, 8'h02, 8'h01};
    int num_errors = 0, checks_done = 0;
    nand_card_ctrl nand_card_ctrl_i (.mclk_i, .nrst_i, .req_i, .req_valid_i, .req_ready_o,
        .tim_i, .nand_wide_i, .rsp_valid_o, .rsp_error_o, .rsp_rdata_o, .mem_addr_o(addr),
        .data_i(din), .data_o(dout), .data_oe_o, .bank_select_n_o(bsel_n),
        .out_strobe_n_o(out_n), .write_strobe_n_o(wr_n), .io_read_strobe_n_o(ior_n),
        .io_write_strobe_n_o(iow_n), .space_select_n_o(ssel_n), .card_select_lo_n_o(clo_n),
        .card_select_hi_n_o(chi_n), .ready_busy_i(rb), .wait_in_n_i(wait_n), .card_irq_in_i,
        .card_present_i, .io_wide_indicate_n_i(1'b0), .card_irq_o, .io_wide_fault_o);
    nand_card_mem nand_card_mem_i (.mclk_i, .mem_addr_i(addr), .data_i(dout), .oe_i(data_oe_o),
        .bank_select_n_i(bsel_n), .strb_n_i({out_n, wr_n, ior_n, iow_n}),
        .card_i({ssel_n, clo_n, chi_n}), .data_o(din), .ready_busy_o(rb), .wait_in_n_o(wait_n));
    // 125 MHz clock
    initial
    begin
        forever #4 mclk_i = ~mclk_i;
    end
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic results;
        if (num_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Expected flash byte at an address
    function automatic logic [7:0] pb(input logic [25:0] a);
        return a[7:0] ^ 8'hc3;
    endfunction
    // One request, wait for the one-cycle answer
    task automatic xfer(input logic w, input logic [1:0] b, input logic [1:0] s,
        input logic [1:0] z, input logic [25:0] a, input logic [31:0] d);
        int n;
        nand_card_mem_i.n_rd = 0;
        nand_card_mem_i.n_wr = 0;
        nand_card_mem_i.n_ior = 0;
        nand_card_mem_i.n_iow = 0;
        nand_card_mem_i.wa.delete();
        nand_card_mem_i.wd.delete();
        @(posedge mclk_i);
        #1;
        req_i = '{w, b, s, z, a, d};
        req_valid_i = 1;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 100)
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        // A request never taken counts as a mismatch
        if (n >= 100)
            num_errors++;
        @(posedge mclk_i);
        #1;
        req_valid_i = 0;
        n = 0;
        while (rsp_valid_o !== 1'b1 && n < 3000)
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        // A missing answer counts as a mismatch
        if (n >= 3000)
            num_errors++;
        rerr = rsp_error_o;
        rdat = rsp_rdata_o;
    endtask
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        num_errors++;
        results();
    end
    // Directed sequence
    initial
    begin
        repeat (4) @(posedge mclk_i);
        #1;
        nrst_i = 1;
        nand_card_mem_i.busy_len = 5;
        nand_card_mem_i.wait_len = 2;
        // Byte NAND word write, address latch line high
        xfer(1, BANK_N2, SPC_COMMON, SZ_32, 26'h002_0000, 32'h4433_2211);
        chk(rerr, 0);
        chk(nand_card_mem_i.n_wr, 4);
        chk(nand_card_mem_i.n_rd, 0);
        for (int i = 0; i < 4; i++)
        begin
            chk(nand_card_mem_i.wa[i], 26'h002_0000 + i);
            chk(nand_card_mem_i.wd[i][7:0], 8'h11 * (i + 1));
        end
        chk(nand_card_mem_i.min_w >= 4, 1);
        chk(nand_card_mem_i.min_su >= 3, 1);
        chk(nand_card_mem_i.bank_seen, 2'b01);
        chk(nand_card_mem_i.viol, 0);
        // Wide NAND word read, command latch line high
        xfer(0, BANK_N3, SPC_COMMON, SZ_32, 26'h001_0010, '0);
        chk(rdat, {16'h0012 ^ 16'ha5c3, 16'h0010 ^ 16'ha5c3});
        chk(nand_card_mem_i.n_rd, 2);
        chk(nand_card_mem_i.bank_seen, 2'b10);
        chk(addr, 26'h001_0012);
        // Byte write to wide NAND is refused
        xfer(1, BANK_N3, SPC_COMMON, SZ_8, 26'h000_0004, 32'h0000_0055);
        chk({rerr, nand_card_mem_i.n_wr[2:0]}, 4'h8);
        // Byte NAND half-word read
        xfer(0, BANK_N2, SPC_COMMON, SZ_16, 26'h000_0101, '0);
        chk(rdat[15:0], {pb(26'h102), pb(26'h101)});
        // Card bank with no card
        xfer(0, BANK_CARD, SPC_COMMON, SZ_16, 26'h000_0040, '0);
        chk({rerr, nand_card_mem_i.n_rd[2:0]}, 4'h8);
        card_present_i = 1;
        // Every card space, half-word read
        for (int s = 0; s < 3; s++)
        begin
            xfer(0, BANK_CARD, s[1:0], SZ_16, 26'h000_0040, '0);
            chk(rerr, 0);
            chk(nand_card_mem_i.n_rd, s != 2);
            chk(nand_card_mem_i.n_ior, s == 2);
            chk(nand_card_mem_i.card_seen, {s == 0, 2'b00});
            chk(rdat[15:0], 16'h0040 ^ 16'ha5c3);
        end
        // Card I/O write
        xfer(1, BANK_CARD, SPC_IO, SZ_16, 26'h000_0044, 32'h0000_beef);
        chk({nand_card_mem_i.n_iow[3:0], nand_card_mem_i.n_wr[3:0]}, 8'h10);
        chk(nand_card_mem_i.wd[0], 16'hbeef);
        chk(io_wide_fault_o, 0);
        // Card wait input stretches the strobe past its count
        nand_card_mem_i.wait_len = 8;
        xfer(0, BANK_CARD, SPC_COMMON, SZ_16, 26'h000_0046, '0);
        chk(nand_card_mem_i.w_last, 10);
        nand_card_mem_i.wait_len = 2;
        // Odd byte read uses only the upper select
        xfer(0, BANK_CARD, SPC_ATTR, SZ_8, 26'h000_0041, '0);
        chk(nand_card_mem_i.card_seen, 3'b010);
        chk(rdat[7:0], 8'ha5);
        // Card interrupt passes through one cycle late
        card_irq_in_i = 1;
        chk(card_irq_o, 0);
        @(posedge mclk_i);
        #1;
        chk(card_irq_o, 1);
        results();
    end
endmodule // nand_pccard_access_controller_test
